// ### tmrps_pkg.sv
// Shared constants, state layouts and phase encoding for the timer/counter with prescaler.
package tmrps_pkg;

  // ==========================================================================
  // Register map and option field layout
  // ==========================================================================
  localparam logic [4:0] TMR_ADDR = 5'h01;
  localparam int CS_BIT = 5;
  localparam int SE_BIT = 4;
  localparam int PSA_BIT = 3;
  localparam int PS_MSB = 2;
  localparam logic [5:0] OPT_RESET = 6'h3f;
  localparam logic [7:0] TMR_RESET = 8'h00;
  localparam logic [7:0] PSC_RESET = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int TOSC_NS = 20;
  localparam int TOSC_CYC = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] INHIB_CYC = 2'h2;
  localparam int EXT_LEVEL_MIN_NS = 2 * TOSC_NS + 20;
  localparam int EXT_LEVEL_MIN_CYC = (EXT_LEVEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_PERIOD_PSC_MIN_NS = 4 * TOSC_NS + 40;
  localparam int EXT_PULSE_MIN_NS = 10;
  localparam int LAT_MIN_TOSC = 3;
  localparam int LAT_MAX_TOSC = 7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } tmrps_phase_t;

  typedef struct packed {
    tmrps_phase_t phase;
    logic [5:0] option;
    logic [7:0] count;
    logic [1:0] inhib;
    logic s1;
    logic s2;
    logic s3;
    logic smp;
    logic smp_prev;
    logic psc_prev;
    logic [7:0] rdata;
    logic wdt_out;
  } tmrps_state_t;

  typedef struct packed {
    logic [7:0] count;
  } tmrps_psc_state_t;

endpackage

// ### tmrps_psc_if.sv
// Control and status link between the timer core and its prescaler.
`timescale 1ns/1ps
interface tmrps_psc_if;
  logic ce;
  logic clr;
  logic tick;
  logic [2:0] ratio;
  logic [7:0] count;
  logic level;

  modport ctrl (output ce, output clr, output tick, output ratio, input count, input level);
  modport psc (input ce, input clr, input tick, input ratio, output count, output level);
endinterface

// ### tmrps_prescaler.sv
// Shared eight-bit prescaler counter with selectable output tap.
`timescale 1ns/1ps
module tmrps_prescaler (
  input wire logic core_clk,
  input wire logic rst,
  tmrps_psc_if.psc p
);

  // ==========================================================================
  // State
  // ==========================================================================
  tmrps_pkg::tmrps_psc_state_t st_ff;
  tmrps_pkg::tmrps_psc_state_t nxt_st;

  // A binary count behaves like the ripple chain: tap n rises once per 2^(n+1) ticks.
  always_comb
  begin
    nxt_st = st_ff;
    if (p.clr)
    begin
      nxt_st.count = tmrps_pkg::PSC_RESET;
    end
    else if (p.tick)
    begin
      nxt_st.count = st_ff.count + 8'h01;
    end
  end

  // Reset loads zeros; the clock enable freezes the count.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_ff <= '{count: tmrps_pkg::PSC_RESET};
    end
    else if (p.ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // The tap is a plain counter bit, so its output is symmetrical.
  assign p.count = st_ff.count;
  assign p.level = st_ff.count[p.ratio];

endmodule

// ### tmrps_top.sv
// Eight-bit timer/counter with shared prescaler, option register and input synchroniser.
`timescale 1ns/1ps

// Notes on behaviour
// - Clock source 0 counts one per instruction cycle or per prescaler output.
// - A write to the count holds off counting for two instruction cycles.
// - Clock source 1 counts external input edges instead of instruction cycles.
// - Edge select 0 counts rising edges, 1 counts falling edges.
// - Prescaler serves the counter when assign is 0, the watchdog when 1.
// - Counter prescale ratios run from 1:2 to 1:256 in powers of two.
// - Software can neither read nor write the prescaler count.
// - Prescaler output or raw input is sampled on second and fourth phases.
// - Prescaler is a ripple style counter fed by the input, symmetric output.
// - Count updates three to seven oscillator periods after an active edge.
// - With counter assignment, every count write clears the prescaler.
// - With watchdog assignment, the watchdog clear clears the prescaler.
// - Any reset loads the prescaler with zeros.
// - For the watchdog the prescaler is a postscaler; the timer then runs unscaled.
// - The count is a readable and writable byte at data address 01h.
module tmrps_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic opt_wr,
  input wire logic [5:0] opt_wdata,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_timeout_raw,
  input wire logic external_count_input,
  output logic [7:0] timer_count_reg,
  output logic watchdog_timeout_post,
  output logic prescaler_assign
);

  // ==========================================================================
  // State and local nets
  // ==========================================================================
  tmrps_pkg::tmrps_state_t st_ff;
  tmrps_pkg::tmrps_state_t nxt_st;
  tmrps_psc_if psc_bus ();

  logic clock_source_select;
  logic source_edge_select;
  logic [2:0] prescale_ratio;
  logic wr_hit;
  logic instr_tick;
  logic ext_lvl;
  logic ext_edge;
  logic src_lvl;
  logic direct_mode;
  logic smp_edge;
  logic inc_req;
  logic do_inc;

  // ==========================================================================
  // Prescaler instance
  // ==========================================================================
  tmrps_prescaler u_psc (
    .core_clk (core_clk),
    .rst (rst),
    .p (psc_bus.psc)
  );

  // ==========================================================================
  // Decode of option fields and bus strobes
  // ==========================================================================

  // Option fields steer the source, edge, assignment and ratio.
  assign clock_source_select = st_ff.option[tmrps_pkg::CS_BIT];
  assign source_edge_select = st_ff.option[tmrps_pkg::SE_BIT];
  assign prescaler_assign = st_ff.option[tmrps_pkg::PSA_BIT];
  assign prescale_ratio = st_ff.option[tmrps_pkg::PS_MSB:0];

  // A count write is a data write to the count address.
  assign wr_hit = reg_wr && (reg_addr == tmrps_pkg::TMR_ADDR);

  // The instruction cycle ends with the fourth phase.
  assign instr_tick = (st_ff.phase == tmrps_pkg::PH_Q4);

  // ==========================================================================
  // Source selection
  // ==========================================================================

  // Inverting the synced pin turns the chosen edge into a rising one.
  assign ext_lvl = st_ff.s2 ^ source_edge_select;
  assign ext_edge = ext_lvl && !(st_ff.s3 ^ source_edge_select);

  // Prescaler input follows its assignment, which is exclusive.
  assign psc_bus.ce = clk_en;
  assign psc_bus.ratio = prescale_ratio;
  assign psc_bus.tick = prescaler_assign ? watchdog_timeout_raw :
                        (clock_source_select ? ext_edge : instr_tick);

  // Prescaler clears on count writes or watchdog clears, per assignment.
  assign psc_bus.clr = (wr_hit && !prescaler_assign) ||
                       (watchdog_clear_instr && prescaler_assign);

  // The sampled source is the prescaler tap, or the raw input when unscaled.
  assign src_lvl = (clock_source_select && prescaler_assign) ? ext_lvl : psc_bus.level;

  // Timer mode without prescaler counts straight from the instruction cycle.
  assign direct_mode = !clock_source_select && prescaler_assign;
  assign smp_edge = st_ff.smp && !st_ff.smp_prev && !direct_mode;
  assign inc_req = (direct_mode && instr_tick) || smp_edge;

  // Increments are dropped while a write is pending or held off.
  assign do_inc = inc_req && (st_ff.inhib == 2'h0) && !wr_hit;

  // ==========================================================================
  // Next state
  // ==========================================================================

  // One pass computes every register of the block.
  always_comb
  begin
    nxt_st = st_ff;

    // Phase sequencer stepping through the four quarter cycles.
    case (st_ff.phase)
      tmrps_pkg::PH_Q1: nxt_st.phase = tmrps_pkg::PH_Q2;
      tmrps_pkg::PH_Q2: nxt_st.phase = tmrps_pkg::PH_Q3;
      tmrps_pkg::PH_Q3: nxt_st.phase = tmrps_pkg::PH_Q4;
      tmrps_pkg::PH_Q4: nxt_st.phase = tmrps_pkg::PH_Q1;
      default: nxt_st.phase = tmrps_pkg::PH_Q1;
    endcase

    // Two-stage synchroniser on the pin, plus a history stage for edges.
    nxt_st.s1 = external_count_input;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;

    // The source is sampled only on the second and fourth phases.
    if ((st_ff.phase == tmrps_pkg::PH_Q2) || (st_ff.phase == tmrps_pkg::PH_Q4))
    begin
      nxt_st.smp = src_lvl;
    end
    nxt_st.smp_prev = st_ff.smp;

    // Option register is loaded whole by the option instruction.
    if (opt_wr)
    begin
      nxt_st.option = opt_wdata;
    end

    // Count write wins over an increment and restarts the hold-off.
    if (wr_hit)
    begin
      nxt_st.count = reg_wdata;
      nxt_st.inhib = tmrps_pkg::INHIB_CYC;
    end
    else
    begin
      if (instr_tick && (st_ff.inhib != 2'h0))
      begin
        nxt_st.inhib = st_ff.inhib - 2'h1;
      end
      if (do_inc)
      begin
        nxt_st.count = st_ff.count + 8'h01;
      end
    end

    // Read data shows the count at its address and zero elsewhere.
    nxt_st.rdata = (reg_addr == tmrps_pkg::TMR_ADDR) ? st_ff.count : 8'h00;

    // Watchdog time-out passes raw, or once per prescaler tap rise.
    nxt_st.psc_prev = psc_bus.level;
    if (prescaler_assign)
    begin
      nxt_st.wdt_out = psc_bus.level && !st_ff.psc_prev;
    end
    else
    begin
      nxt_st.wdt_out = watchdog_timeout_raw;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================

  // Synchronous reset first; the clock enable freezes everything else.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_ff <= '{
        phase: tmrps_pkg::PH_Q1,
        option: tmrps_pkg::OPT_RESET,
        count: tmrps_pkg::TMR_RESET,
        inhib: 2'h0,
        s1: 1'b0,
        s2: 1'b0,
        s3: 1'b0,
        smp: 1'b1, // The reset option samples a high idle level, so no false edge follows.
        smp_prev: 1'b1,
        psc_prev: 1'b0,
        rdata: 8'h00,
        wdt_out: 1'b0
      };
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = st_ff.rdata;
  assign timer_count_reg = st_ff.count;
  assign watchdog_timeout_post = st_ff.wdt_out;

  // ==========================================================================
  // Assertions
  // ==========================================================================

  // A write holds for the next seven clocks, across two suppressed ticks.
  a_write_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_hit) ##1 (clk_en && !wr_hit)[*7]
    |-> (st_ff.count == $past(reg_wdata, 7)))
    else $error("count changed during write hold-off");

  // Timer mode without prescaler adds exactly one per instruction cycle.
  a_timer_rate: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && instr_tick && direct_mode && (st_ff.inhib == 2'h0) && !wr_hit)
    |=> (st_ff.count == 8'($past(st_ff.count) + 8'h01)))
    else $error("timer missed an instruction cycle increment");

  // Counter mode never counts without a sampled edge.
  a_ext_only: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && clock_source_select && !wr_hit && !smp_edge)
    |=> $stable(st_ff.count))
    else $error("counter mode counted without a sampled edge");

  // The count rolls over from ff to 00.
  a_count_wrap: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && do_inc && (st_ff.count == 8'hff))
    |=> (st_ff.count == 8'h00))
    else $error("count did not wrap to zero");

  // The sample changes only after a second or fourth phase.
  a_sample_phase: assert property (
    @(posedge core_clk) disable iff (rst)
    $changed(st_ff.smp)
    |-> (($past(st_ff.phase) == tmrps_pkg::PH_Q2) || ($past(st_ff.phase) == tmrps_pkg::PH_Q4)))
    else $error("source sampled outside second or fourth phase");

  // Count writes clear the prescaler when it serves the counter.
  a_psc_wrclr: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_hit && !prescaler_assign)
    |=> (psc_bus.count == 8'h00))
    else $error("count write left prescaler uncleared");

  // Watchdog clear clears the prescaler when it serves the watchdog.
  a_psc_wdtclr: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && watchdog_clear_instr && prescaler_assign)
    |=> (psc_bus.count == 8'h00))
    else $error("watchdog clear left prescaler uncleared");

  // Reset loads the prescaler with zeros.
  a_psc_reset: assert property (
    @(posedge core_clk)
    rst |=> (psc_bus.count == 8'h00))
    else $error("prescaler not zero after reset");

  // Without the prescaler the watchdog time-out passes straight through.
  a_wdt_direct: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !prescaler_assign && watchdog_timeout_raw)
    |=> watchdog_timeout_post)
    else $error("unscaled watchdog time-out lost");

  // Reads of the count address return the count of the cycle before.
  a_read_back: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && (reg_addr == tmrps_pkg::TMR_ADDR))
    |=> (reg_rdata == $past(st_ff.count)))
    else $error("count read-back mismatch");

  // Reads of any other address return zero, never the prescaler.
  a_read_other: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && (reg_addr != tmrps_pkg::TMR_ADDR))
    |=> (reg_rdata == 8'h00))
    else $error("read of another address returned data");

  // A count write loads the value and restarts the hold-off.
  a_write_load: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && wr_hit)
    |=> ((timer_count_reg == $past(reg_wdata)) && (st_ff.inhib == tmrps_pkg::INHIB_CYC)))
    else $error("count write not loaded or hold-off not started");

  // The count stands while the hold-off is still running.
  a_holdoff_stable: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && (st_ff.inhib != 2'h0) && !wr_hit)
    |=> $stable(st_ff.count))
    else $error("count moved during hold-off");

  // A watchdog-owned prescaler moves only on a time-out or a clear.
  a_psc_excl: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && prescaler_assign && !watchdog_timeout_raw && !watchdog_clear_instr)
    |=> $stable(psc_bus.count))
    else $error("watchdog prescaler moved without a time-out");

  // A counter-owned prescaler steps by one on each source tick.
  a_psc_step: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !prescaler_assign && psc_bus.tick && !psc_bus.clr)
    |=> (psc_bus.count == 8'($past(psc_bus.count) + 8'h01)))
    else $error("prescaler missed a source tick");

  // Unscaled counter mode samples the edge-adjusted pin level.
  a_direct_sample: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && clock_source_select && prescaler_assign &&
     ((st_ff.phase == tmrps_pkg::PH_Q2) || (st_ff.phase == tmrps_pkg::PH_Q4)))
    |=> (st_ff.smp == $past(ext_lvl)))
    else $error("unscaled pin level not sampled");

  // Each rise of the watchdog tap gives one post-scaled pulse.
  a_post_tap: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && prescaler_assign && psc_bus.level && !st_ff.psc_prev)
    |=> watchdog_timeout_post)
    else $error("post-scaled time-out pulse missing");

endmodule

// ### tmrps_ext_src.sv
// Behavioural source of pulses on the external count pin.
`timescale 1ns/1ps
module tmrps_ext_src (
  input wire logic core_clk,
  input wire logic want,
  output logic pin
);
  // ==========================================================================
  // Pin level follows the request once the present level has stood long enough
  // ==========================================================================
  int held = 0;
  initial pin = 1'b0;
  // A change is held back until the present level has met its minimum time.
  always @(posedge core_clk)
  begin
    if (want !== pin && held >= tmrps_pkg::EXT_LEVEL_MIN_CYC)
    begin
      pin <= want;
      held <= 1;
    end
    else
    begin
      held <= held + 1;
    end
  end
endmodule

// ### tmrps_top_tb.sv
// Self-checking testbench for the timer/counter with prescaler.
`timescale 1ns/1ps
module tmrps_top_tb;
  // ==========================================================================
  // Signals and counters
  // ==========================================================================
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic opt_wr = 1'b0;
  logic [5:0] opt_wdata = 6'h00;
  logic wdog_clr = 1'b0;
  logic wdog_raw = 1'b0;
  logic pin_want = 1'b0;
  logic ext_pin;
  logic [7:0] cnt;
  logic wdog_post;
  logic assign_q;
  logic [7:0] a;
  int err_total = 0;
  int compares = 0;
  int posts = 0;
  int p0;
  int k;

  // The clock toggles every half period of 10 ns.
  always #10 core_clk = ~core_clk;

  // Post-scaled pulses are tallied for later comparison.
  always @(posedge core_clk) if (wdog_post === 1'b1) posts <= posts + 1;

  // ==========================================================================
  // Design and far side
  // ==========================================================================
  tmrps_top tmrps_top_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .opt_wr(opt_wr),
    .opt_wdata(opt_wdata), .watchdog_clear_instr(wdog_clr), .watchdog_timeout_raw(wdog_raw),
    .external_count_input(ext_pin), .timer_count_reg(cnt), .watchdog_timeout_post(wdog_post),
    .prescaler_assign(assign_q));
  tmrps_ext_src tmrps_ext_src_i (.core_clk(core_clk), .want(pin_want), .pin(ext_pin));

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic wopt(input logic [5:0] v);
    @(posedge core_clk);
    opt_wr <= 1'b1;
    opt_wdata <= v;
    @(posedge core_clk);
    opt_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= ad;
    @(posedge core_clk);
    #1;
    chk("rdata", reg_rdata, exp);
  endtask

  task automatic clr_wdog;
    @(posedge core_clk);
    wdog_clr <= 1'b1;
    @(posedge core_clk);
    wdog_clr <= 1'b0;
  endtask

  task automatic raw(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      wdog_raw <= 1'b1;
      @(posedge core_clk);
      wdog_raw <= 1'b0;
    end
  endtask

  // Returns once the pin has taken the level, just after the edge that moved it.
  task automatic set_pin(input logic v);
    int n;
    @(posedge core_clk);
    pin_want <= v;
    n = 0;
    while (ext_pin !== v && n < 20)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  // Counts edges until the count leaves the given value.
  task automatic wchg(input logic [7:0] base);
    k = 0;
    while (cnt === base && k < 100)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang is cut short well beyond the length of the whole sequence.
  initial
  begin
    tick(50000);
    err_total++;
    summarize();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    tick(5);
    rst <= 1'b0;
    tick(1);
    #1;
    chk("count", cnt, tmrps_pkg::TMR_RESET);
    chk("assign", {7'h00, assign_q}, 8'h01);
    chk("rdata", reg_rdata, 8'h00);
    p0 = posts;
    raw(127);
    tick(4);
    chk("posts", 8'(posts - p0), 8'h00);
    raw(1);
    tick(4);
    chk("posts", 8'(posts - p0), 8'h01);
    chk("count", cnt, tmrps_pkg::TMR_RESET);
    wopt(6'h29);
    clr_wdog();
    raw(1);
    clr_wdog();
    p0 = posts;
    raw(1);
    tick(4);
    chk("posts", 8'(posts - p0), 8'h00);
    raw(6);
    tick(4);
    chk("posts", 8'(posts - p0), 8'h02);
    clr_wdog();
    wopt(6'h20);
    tick(2);
    chk("assign", {7'h00, assign_q}, 8'h00);
    p0 = posts;
    raw(3);
    tick(4);
    chk("posts", 8'(posts - p0), 8'h03);
    wr(5'h01, 8'ha5);
    rd(5'h01, 8'ha5);
    rd(5'h02, 8'h00);
    wr(5'h02, 8'h5a);
    rd(5'h01, 8'ha5);
    wr(5'h01, 8'h00);
    repeat (8)
    begin
      set_pin(1'b1);
      set_pin(1'b0);
    end
    tick(10);
    #1;
    chk("count", cnt, 8'h04);
    clr_wdog();
    wr(5'h01, 8'h00);
    wopt(6'h28);
    tick(12);
    a = cnt;
    set_pin(1'b1);
    wchg(a);
    chk("lat", {7'h00, k >= 3 && k <= 7}, 8'h01);
    a = cnt;
    set_pin(1'b0);
    tick(10);
    #1;
    chk("count", cnt, a);
    wopt(6'h38);
    tick(12);
    #1;
    a = cnt;
    set_pin(1'b1);
    tick(10);
    #1;
    chk("count", cnt, a);
    set_pin(1'b0);
    wchg(a);
    chk("lat", {7'h00, k >= 3 && k <= 7}, 8'h01);
    chk("count", cnt, a + 8'h01);
    wopt(6'h08);
    wr(5'h01, 8'hfa);
    tick(16);
    #1;
    a = cnt;
    tick(40);
    #1;
    chk("count", cnt, a + 8'h0a);
    wchg(cnt);
    wr(5'h01, 8'h30);
    chk("count", cnt, 8'h30);
    wchg(8'h30);
    chk("holdoff", 8'(k), 8'h0a);
    @(posedge core_clk);
    clk_en <= 1'b0;
    tick(1);
    #1;
    a = cnt;
    tick(40);
    #1;
    chk("count", cnt, a);
    @(posedge core_clk);
    clk_en <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      clr_wdog();
      wopt(6'(n));
      wr(5'h01, 8'h00);
      tick((8 << n) + 16);
      #1;
      a = cnt;
      tick(2 * (8 << n));
      #1;
      chk("count", cnt, a + 8'h02);
    end
    wopt(6'h03);
    wchg(cnt);
    tick(48);
    wr(5'h01, 8'h50);
    tick(26);
    #1;
    chk("count", cnt, 8'h50);
    wchg(8'h50);
    chk("count", {7'h00, k <= 18}, 8'h01);
    summarize();
  end
endmodule
